// ### pkg/irq_ctrl_pkg.sv
package irq_ctrl_pkg;
   // Source counts and their places in the flat source vector
   localparam int EXT_N = 12;
   localparam int INT_N = 22;
   localparam int TMR_N = 4;
   localparam int MSG_N = 4;
   localparam int IPI_N = 4;
   localparam int INT_B = EXT_N;
   localparam int TMR_B = INT_B + INT_N;
   localparam int MSG_B = TMR_B + TMR_N;
   localparam int IPI_B = MSG_B + MSG_N;
   localparam int SRC_N = IPI_B + IPI_N;
   localparam int DEST_N = IPI_B;
   // Field widths
   localparam int PRIO_W = 4;
   localparam int VEC_W = 8;
   localparam int IDX_W = 6;
   localparam int CNT_W = 31;
   localparam int HALF_W = 16;
   localparam int SEL_W = 3;
   localparam int PRE_W = 8;
   localparam int SUM_W = 32;
   // Reset and fixed values
   localparam logic [VEC_W-1:0] SPURIOUS_VEC = 8'hFF;
   localparam logic [31:0] CLK_HZ = 32'h017D7840;
   localparam logic [PRE_W-1:0] PRE_ONE = 8'h01;
   localparam logic [CNT_W-1:0] CNT_ONE = 31'h00000001;
   // Destination selector of a source
   typedef enum logic [1:0]
   {
      DEST_NORMAL = 2'h0,
      DEST_CRIT = 2'h1,
      DEST_PIN = 2'h2
   } dest_e;
endpackage

// ### src/irq_ctrl.sv
`timescale 1ns/10ps
module irq_ctrl
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Global configuration
   input wire logic global_reset_in,
   input wire logic mixed_mode_in,
   // Interrupt sources
   input wire logic [irq_ctrl_pkg::EXT_N-1:0] ext_irq_in,
   input wire logic [irq_ctrl_pkg::INT_N-1:0] int_irq_in,
   input wire logic [irq_ctrl_pkg::MSG_N-1:0] msg_evt_in,
   input wire logic [irq_ctrl_pkg::IPI_N-1:0] ipi_evt_in,
   // Per-source configuration
   input wire logic [irq_ctrl_pkg::SRC_N-1:0][irq_ctrl_pkg::PRIO_W-1:0] src_prio_in,
   input wire logic [irq_ctrl_pkg::SRC_N-1:0][irq_ctrl_pkg::VEC_W-1:0] src_vec_in,
   input wire logic [irq_ctrl_pkg::SRC_N-1:0] src_mask_in,
   input wire logic [irq_ctrl_pkg::DEST_N-1:0][1:0] src_dest_in,
   input wire logic [irq_ctrl_pkg::EXT_N-1:0] ext_pol_in,
   input wire logic [irq_ctrl_pkg::EXT_N-1:0] ext_level_in,
   // Processor handshake
   input wire logic [irq_ctrl_pkg::PRIO_W-1:0] current_task_priority_in,
   input wire logic ack_read_in,
   input wire logic eoi_write_in,
   output logic [irq_ctrl_pkg::VEC_W-1:0] ack_vec_out,
   output logic core_int_out,
   output logic core_cint_out,
   output logic irq_pin_out,
   output logic [irq_ctrl_pkg::SUM_W-1:0] critical_summary_0_out,
   output logic [irq_ctrl_pkg::SUM_W-1:0] critical_summary_1_out,
   // Global timers
   input wire logic [irq_ctrl_pkg::TMR_N-1:0][irq_ctrl_pkg::CNT_W-1:0] timer_base_count_in,
   input wire logic [irq_ctrl_pkg::TMR_N-1:0] timer_load_in,
   input wire logic [irq_ctrl_pkg::TMR_N-1:0] timer_inhibit_in,
   input wire logic [irq_ctrl_pkg::SEL_W-1:0] timer_freq_sel_in,
   input wire logic [1:0] timer_cascade_in,
   output logic [irq_ctrl_pkg::TMR_N-1:0][irq_ctrl_pkg::CNT_W-1:0] timer_current_count_out,
   output logic [31:0] timer_freq_report_out
);
   import irq_ctrl_pkg::*;

   typedef struct packed
   {
      logic [EXT_N-1:0] s1;
      logic [EXT_N-1:0] s2;
      logic [EXT_N-1:0] s3;
      logic [EXT_N-1:0] lvl;
      logic [EXT_N-1:0] act_d;
      logic [3:0] warm;
      logic [SRC_N-1:0] pend;
      logic [SRC_N-1:0] isv;
      logic [SRC_N-1:0] csum;
      logic [TMR_N-1:0][CNT_W-1:0] cnt;
      logic [PRE_W-1:0] pre;
      logic [31:0] freq;
      logic core_int;
      logic core_cint;
      logic irq_pin;
      logic [VEC_W-1:0] vec;
   } state_s;

   state_s st_r;
   state_s st_nxt;

   // Highest-priority member of a set; lowest index wins a tie
   function automatic logic [PRIO_W+IDX_W:0] pick(input logic [SRC_N-1:0] m,
      input logic [SRC_N-1:0][PRIO_W-1:0] p);
      logic [PRIO_W+IDX_W:0] best;
      best = '0;
      for (int i = 0; i < SRC_N; i++)
      begin
         if (m[i] && (!best[PRIO_W+IDX_W] || p[i] > best[PRIO_W+IDX_W-1:IDX_W]))
         begin
            best = {1'b1, p[i], IDX_W'(i)};
         end
      end
      return best;
   endfunction

   logic [EXT_N-1:0] ext_act;
   logic [SRC_N-1:0] edge_src;
   logic [SRC_N-1:0] live;
   logic [SRC_N-1:0] setv;
   logic [SRC_N-1:0] clrv;
   logic [SRC_N-1:0] act;
   logic [SRC_N-1:0] to_norm;
   logic [SRC_N-1:0] to_crit;
   logic [SRC_N-1:0] to_pin;
   logic [PRIO_W+IDX_W:0] best_n;
   logic [PRIO_W+IDX_W:0] best_c;
   logic [PRIO_W+IDX_W:0] best_a;
   logic [PRIO_W+IDX_W:0] top_isv;
   logic ok_n;
   logic ok_c;
   logic ok_a;
   logic tick;
   logic [TMR_N-1:0] wrap;
   logic [TMR_N-1:0] fire;
   logic [TMR_N-1:0] tmr_step;
   logic [CNT_W-1:0] tval;

   // Priority threshold: above task priority and above every in-service level
   function automatic logic above(input logic [PRIO_W+IDX_W:0] b,
      input logic [PRIO_W-1:0] ctp, input logic [PRIO_W+IDX_W:0] top);
      return b[PRIO_W+IDX_W] && b[PRIO_W+IDX_W-1:IDX_W] > ctp &&
         (!top[PRIO_W+IDX_W] || b[PRIO_W+IDX_W-1:IDX_W] > top[PRIO_W+IDX_W-1:IDX_W]);
   endfunction

   // Next-state logic for the whole controller
   always_comb
   begin
      st_nxt = st_r;
      // Three-stage pin synchroniser; a level counts once stages two and three agree
      st_nxt.s1 = ext_irq_in;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      st_nxt.warm = {st_r.warm[2:0], 1'b1}; // Stages fill one by one after any reset
      for (int i = 0; i < EXT_N; i++)
      begin
         if (st_r.warm[2] && st_r.s2[i] == st_r.s3[i])
         begin
            st_nxt.lvl[i] = st_r.s3[i];
         end
      end
      ext_act = st_r.warm[3] ? ~(st_r.lvl ^ ext_pol_in) : '0;
      st_nxt.act_d = ext_act;
      // Shared prescaler, divide by two to the power of the select
      tick = st_r.pre >= PRE_W'((PRE_ONE << timer_freq_sel_in) - PRE_ONE);
      st_nxt.pre = tick ? '0 : PRE_W'(st_r.pre + PRE_ONE);
      st_nxt.freq = CLK_HZ >> timer_freq_sel_in;
      // Timers; in cascade the pair runs on 16-bit halves, low half clocks high
      wrap = '0;
      fire = '0;
      tmr_step = '0;
      for (int i = 0; i < TMR_N; i++)
      begin
         tmr_step[i] = (i % 2 == 1 && timer_cascade_in[i/2]) ? wrap[(i/2)*2] : tick;
         tval = timer_cascade_in[i/2] ? {15'h0000, st_r.cnt[i][HALF_W-1:0]} : st_r.cnt[i];
         if (timer_load_in[i])
         begin
            st_nxt.cnt[i] = timer_base_count_in[i];
         end
         else if (tmr_step[i] && !timer_inhibit_in[i])
         begin
            if (tval <= CNT_ONE)
            begin
               // Reload keeps periodic interrupts going without software
               st_nxt.cnt[i] = timer_cascade_in[i/2] ?
                  {15'h0000, timer_base_count_in[i][HALF_W-1:0]} :
                  timer_base_count_in[i];
               wrap[i] = 1'b1;
            end
            else
            begin
               st_nxt.cnt[i] = CNT_W'(tval - CNT_ONE);
            end
         end
         // Low half of a cascaded pair raises nothing itself
         fire[i] = wrap[i] && !(i % 2 == 0 && timer_cascade_in[i/2]);
      end
      // Source classes: edge events latch, level sources follow the line
      edge_src = {{(IPI_N+MSG_N+TMR_N){1'b1}}, {INT_N{1'b0}}, ~ext_level_in};
      live = {{(IPI_N+MSG_N+TMR_N){1'b0}}, int_irq_in, ext_act};
      setv = {ipi_evt_in, msg_evt_in, fire & ~st_r.pend[TMR_B+:TMR_N] & ~st_r.isv[TMR_B+:TMR_N],
         {INT_N{1'b0}}, ext_act & ~st_r.act_d};
      // Arbitration per core line
      act = st_r.pend & ~src_mask_in;
      for (int i = 0; i < SRC_N; i++)
      begin
         if (i < DEST_N)
         begin
            to_norm[i] = act[i] && src_dest_in[i] == DEST_NORMAL;
            to_crit[i] = act[i] && src_dest_in[i] == DEST_CRIT;
            to_pin[i] = act[i] && src_dest_in[i] == DEST_PIN;
         end
         else
         begin
            // Inter-processor sources have no destination choice
            to_norm[i] = act[i];
            to_crit[i] = 1'b0;
            to_pin[i] = 1'b0;
         end
      end
      best_n = pick(to_norm, src_prio_in);
      best_c = pick(to_crit, src_prio_in);
      best_a = pick(to_norm | to_crit, src_prio_in);
      top_isv = pick(st_r.isv, src_prio_in);
      ok_n = above(best_n, current_task_priority_in, top_isv);
      ok_c = above(best_c, current_task_priority_in, top_isv);
      ok_a = above(best_a, current_task_priority_in, top_isv);
      // Acknowledge and end-of-interrupt
      clrv = '0;
      st_nxt.isv = st_r.isv;
      if (eoi_write_in && mixed_mode_in && top_isv[PRIO_W+IDX_W])
      begin
         st_nxt.isv[top_isv[IDX_W-1:0]] = 1'b0;
      end
      st_nxt.vec = st_r.vec;
      if (ack_read_in)
      begin
         st_nxt.vec = SPURIOUS_VEC;
         if (mixed_mode_in && ok_a)
         begin
            st_nxt.vec = src_vec_in[best_a[IDX_W-1:0]];
            st_nxt.isv[best_a[IDX_W-1:0]] = 1'b1;
            clrv[best_a[IDX_W-1:0]] = 1'b1;
         end
      end
      // A new edge other than a timer expiry in the clearing cycle survives
      st_nxt.pend = ((st_r.pend & ~clrv) | setv) & edge_src | live & ~edge_src;
      st_nxt.csum = to_crit;
      // Delivery; in mixed mode, acknowledge drops the core lines for at least one cycle
      if (mixed_mode_in)
      begin
         st_nxt.core_int = ok_n && !ack_read_in;
         st_nxt.core_cint = ok_c && !ack_read_in;
         st_nxt.irq_pin = |to_pin;
      end
      else
      begin
         st_nxt.core_int = st_r.lvl[0];
         st_nxt.core_cint = 1'b0;
         st_nxt.irq_pin = |int_irq_in;
      end
      // Soft reset from the global configuration
      if (global_reset_in)
      begin
         st_nxt = '0;
         st_nxt.s1 = ext_irq_in;
         st_nxt.s2 = st_r.s1;
         st_nxt.s3 = st_r.s2;
      end
   end

   // Single state register
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from the state register
   assign ack_vec_out = st_r.vec;
   assign core_int_out = st_r.core_int;
   assign core_cint_out = st_r.core_cint;
   assign irq_pin_out = st_r.irq_pin;
   assign critical_summary_0_out = st_r.csum[SUM_W-1:0];
   assign critical_summary_1_out = {{(2*SUM_W-SRC_N){1'b0}}, st_r.csum[SRC_N-1:SUM_W]};
   assign timer_current_count_out = st_r.cnt;
   assign timer_freq_report_out = st_r.freq;

   // Pass-through follows input zero
   pass_thru_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (!mixed_mode_in && !global_reset_in) |=> core_int_out == $past(st_r.lvl[0]))
      else $error("pass-through line wrong");

   // Acknowledge drops both core lines next cycle
   ack_drop_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (ack_read_in && mixed_mode_in) |=> !core_int_out && !core_cint_out)
      else $error("core line not dropped on acknowledge");

   // Granted acknowledge returns the vector and marks service
   ack_grant_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (ack_read_in && mixed_mode_in && ok_a && !global_reset_in) |=>
      ack_vec_out == $past(src_vec_in[best_a[IDX_W-1:0]]) &&
      st_r.isv[$past(best_a[IDX_W-1:0])])
      else $error("acknowledge vector or service mark wrong");

   // Normal line only above task priority
   task_prio_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (mixed_mode_in && !global_reset_in) ##1 core_int_out |->
      $past(best_n[PRIO_W+IDX_W-1:IDX_W]) > $past(current_task_priority_in))
      else $error("interrupt at or below task priority");

   // Nesting honours the in-service level
   nest_block_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (mixed_mode_in && top_isv[PRIO_W+IDX_W] && !global_reset_in &&
      best_c[PRIO_W+IDX_W-1:IDX_W] <= top_isv[PRIO_W+IDX_W-1:IDX_W]) |=> !core_cint_out)
      else $error("critical line preempts in-service level");

   // End-of-interrupt retires the top in-service source
   eoi_retire_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (eoi_write_in && mixed_mode_in && top_isv[PRIO_W+IDX_W] && !ack_read_in) |=>
      !st_r.isv[$past(top_isv[IDX_W-1:0])])
      else $error("end-of-interrupt did not retire");

   // Timer expiry discarded while still pending
   timer_lost_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (fire[0] && st_r.pend[TMR_B] && !ack_read_in && !global_reset_in) |=>
      st_r.pend[TMR_B] && $stable(st_r.isv[TMR_B]))
      else $error("timer expiry disturbed pending state");

   // Uncascaded timer reloads its base on expiry
   timer_reload_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (fire[2] && !timer_cascade_in[1] && !timer_load_in[2] && !global_reset_in) |=>
      st_r.cnt[2] == $past(timer_base_count_in[2]))
      else $error("timer did not reload");

   // Cascaded high timer steps only on the low half's wrap
   cascade_step_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
      (timer_cascade_in[0] && !wrap[0] && !timer_load_in[1] && !global_reset_in) |=>
      $stable(st_r.cnt[1]))
      else $error("cascaded high half stepped without wrap");
endmodule

// ### dv/core_model.sv
`timescale 1ns/10ps
module core_model
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Lines from the controller
   input wire logic core_int_in,
   input wire logic core_cint_in,
   // Bench commands
   input wire logic ack_en_in,
   input wire logic [3:0] delay_in,
   input wire logic eoi_cmd_in,
   // Strobes back to the controller
   output logic ack_read_out,
   output logic eoi_write_out
);
   logic [3:0] wait_r;

   // Answer a raised line after a set latency; the ack strobe lasts one cycle, eoi copies the command a cycle later
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         wait_r <= 4'h0;
         ack_read_out <= 1'b0;
         eoi_write_out <= 1'b0;
      end
      else
      begin
         eoi_write_out <= eoi_cmd_in;
         ack_read_out <= 1'b0;
         // Restart after each strobe so a stale line is never answered twice
         if (ack_read_out || !ack_en_in || !(core_int_in || core_cint_in))
            wait_r <= 4'h0;
         else if (wait_r == delay_in)
            ack_read_out <= 1'b1;
         else
            wait_r <= wait_r + 4'h1;
      end
   end
endmodule

// ### dv/irq_ctrl_tb_top.sv
`timescale 1ns/10ps
module irq_ctrl_tb_top;
   import irq_ctrl_pkg::*;
   logic clk_in = 1'b0, rst_n_in = 1'b0, global_reset_in = 1'b0, mixed_mode_in = 1'b0;
   logic ack_read_in, eoi_write_in, core_int_out, core_cint_out, irq_pin_out;
   logic ack_en = 1'b0, eoi_cmd = 1'b0;
   logic [3:0] delay = 4'h0;
   logic [EXT_N-1:0] ext_irq_in = '0, ext_pol_in = '1, ext_level_in = '1;
   logic [INT_N-1:0] int_irq_in = '0;
   logic [MSG_N-1:0] msg_evt_in = '0;
   logic [IPI_N-1:0] ipi_evt_in = '0;
   logic [SRC_N-1:0][PRIO_W-1:0] src_prio_in = '0;
   logic [SRC_N-1:0][VEC_W-1:0] src_vec_in = '0;
   logic [SRC_N-1:0] src_mask_in = '1;
   logic [DEST_N-1:0][1:0] src_dest_in = '0;
   logic [PRIO_W-1:0] current_task_priority_in = '0;
   logic [VEC_W-1:0] ack_vec_out;
   logic [SUM_W-1:0] critical_summary_0_out, critical_summary_1_out;
   logic [TMR_N-1:0][CNT_W-1:0] timer_base_count_in = '0, timer_current_count_out;
   logic [TMR_N-1:0] timer_load_in = '0, timer_inhibit_in = '1;
   logic [SEL_W-1:0] timer_freq_sel_in = '0;
   logic [1:0] timer_cascade_in = '0;
   logic [31:0] timer_freq_report_out;
   int errors = 0, checks_done = 0;

   always #20 clk_in = ~clk_in;

   irq_ctrl u_irq_ctrl (.clk_in, .rst_n_in, .global_reset_in, .mixed_mode_in, .ext_irq_in,
      .int_irq_in, .msg_evt_in, .ipi_evt_in, .src_prio_in, .src_vec_in, .src_mask_in,
      .src_dest_in, .ext_pol_in, .ext_level_in, .current_task_priority_in, .ack_read_in,
      .eoi_write_in, .ack_vec_out, .core_int_out, .core_cint_out, .irq_pin_out,
      .critical_summary_0_out, .critical_summary_1_out, .timer_base_count_in, .timer_load_in,
      .timer_inhibit_in, .timer_freq_sel_in, .timer_cascade_in, .timer_current_count_out,
      .timer_freq_report_out);

   core_model u_core_model (.clk_in, .rst_n_in, .core_int_in(core_int_out),
      .core_cint_in(core_cint_out), .ack_en_in(ack_en), .delay_in(delay),
      .eoi_cmd_in(eoi_cmd), .ack_read_out(ack_read_in), .eoi_write_out(eoi_write_in));

   // Shared helpers
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   task automatic cfg(input int i, input logic [3:0] p, input logic [7:0] v, input dest_e d);
      src_prio_in[i] <= p;
      src_vec_in[i] <= v;
      src_dest_in[i] <= d;
      src_mask_in[i] <= 1'b0;
   endtask

   task automatic pulse_msg(input int i);
      @(posedge clk_in);
      msg_evt_in[i] <= 1'b1;
      @(posedge clk_in);
      msg_evt_in <= '0;
      cyc(4);
   endtask

   // Let the core model acknowledge, then judge the vector and the line
   task automatic take_ack(input logic [7:0] vec);
      @(posedge clk_in);
      ack_en <= 1'b1;
      repeat (20)
      begin
         @(posedge clk_in);
         if (ack_read_in === 1'b1)
            break;
      end
      #1;
      ack_en <= 1'b0;
      check("ack_vec_out", vec, ack_vec_out);
      check("core line after ack", 0, core_int_out | core_cint_out);
   endtask

   task automatic end_of_interrupt_reg();
      @(posedge clk_in);
      eoi_cmd <= 1'b1;
      @(posedge clk_in);
      eoi_cmd <= 1'b0;
      cyc(4);
   endtask

   task automatic t_pass();
      @(posedge clk_in);
      ext_irq_in <= 12'h002;
      cyc(10);
      check("core_int_out", 0, core_int_out);
      @(posedge clk_in);
      ext_irq_in <= 12'h001;
      int_irq_in[5] <= 1'b1;
      cyc(10);
      check("core_int_out", 1, core_int_out);
      check("irq_pin_out", 1, irq_pin_out);
      @(posedge clk_in);
      ext_irq_in <= '0;
      int_irq_in <= '0;
      cyc(10);
      check("irq_pin_out", 0, irq_pin_out);
      $display("t_pass done");
   endtask

   task automatic t_mixed();
      @(posedge clk_in);
      mixed_mode_in <= 1'b1;
      current_task_priority_in <= 4'h5;
      pulse_msg(0);
      check("core_int_out", 0, core_int_out);
      @(posedge clk_in);
      current_task_priority_in <= 4'h4;
      cyc(3);
      check("core_int_out", 1, core_int_out);
      take_ack(8'h26);
      end_of_interrupt_reg();
      check("core_int_out", 0, core_int_out);
      $display("t_mixed done");
   endtask

   // Slow core answers; nested service against a lowered task priority
   task automatic t_nest();
      @(posedge clk_in);
      current_task_priority_in <= 4'h0;
      delay <= 4'h3;
      pulse_msg(0);
      take_ack(8'h26);
      pulse_msg(2);
      check("core_int_out", 0, core_int_out);
      pulse_msg(1);
      check("core_int_out", 1, core_int_out);
      take_ack(8'h39);
      end_of_interrupt_reg();
      check("core_int_out", 0, core_int_out);
      end_of_interrupt_reg();
      check("core_int_out", 1, core_int_out);
      take_ack(8'h40);
      end_of_interrupt_reg();
      $display("t_nest done");
   endtask

   task automatic t_crit();
      @(posedge clk_in);
      int_irq_in[0] <= 1'b1;
      pulse_msg(3);
      check("core_cint_out", 1, core_cint_out);
      check("core_int_out", 0, core_int_out);
      check("irq_pin_out", 1, irq_pin_out);
      check("critical_summary_1_out", 32'h200, critical_summary_1_out);
      check("critical_summary_0_out", 0, critical_summary_0_out);
      take_ack(8'h41);
      cyc(2);
      check("critical_summary_1_out", 0, critical_summary_1_out);
      @(posedge clk_in);
      int_irq_in <= '0;
      cyc(3);
      check("irq_pin_out", 0, irq_pin_out);
      end_of_interrupt_reg();
      $display("t_crit done");
   endtask

   task automatic t_timer();
      logic [30:0] prev;
      @(posedge clk_in);
      timer_base_count_in[0] <= 31'h5;
      timer_inhibit_in[0] <= 1'b0;
      timer_load_in[0] <= 1'b1;
      @(posedge clk_in);
      timer_load_in <= '0;
      cyc(1);
      prev = timer_current_count_out[0];
      // Every clock is a tick at select zero: down by one, reload after one
      repeat (12)
      begin
         cyc(1);
         check("timer count", (prev == 31'h1) ? 32'h5 : prev - 31'h1,
            timer_current_count_out[0]);
         prev = timer_current_count_out[0];
      end
      check("irq_pin_out", 1, irq_pin_out);
      @(posedge clk_in);
      timer_freq_sel_in <= 3'h2;
      cyc(3);
      check("timer_freq_report_out", 32'h005F5E10, timer_freq_report_out);
      @(posedge clk_in);
      global_reset_in <= 1'b1;
      timer_inhibit_in <= '1;
      @(posedge clk_in);
      global_reset_in <= 1'b0;
      cyc(1);
      check("timer count", 0, timer_current_count_out[0]);
      check("irq_pin_out", 0, irq_pin_out);
      check("ack_vec_out", 0, ack_vec_out);
      cyc(6);
      check("core_int_out", 0, core_int_out);
      $display("t_timer done");
   endtask

   // Active-low edge source: a falling pin latches once, acknowledge clears it
   task automatic t_ext();
      @(posedge clk_in);
      ext_irq_in[3] <= 1'b1;
      ext_pol_in[3] <= 1'b0;
      cyc(8);
      @(posedge clk_in);
      ext_level_in[3] <= 1'b0;
      cfg(3, 4'h7, 8'h03, DEST_NORMAL);
      cyc(3);
      check("core_int_out", 0, core_int_out);
      @(posedge clk_in);
      ext_irq_in[3] <= 1'b0;
      cyc(8);
      check("core_int_out", 1, core_int_out);
      take_ack(8'h03);
      end_of_interrupt_reg();
      check("core_int_out", 0, core_int_out);
      @(posedge clk_in);
      ext_irq_in[3] <= 1'b1;
      $display("t_ext done");
   endtask

   // Timers zero and one cascaded on 16-bit halves; timer two runs alone
   task automatic t_cascade();
      @(posedge clk_in);
      cfg(35, 4'h4, 8'h35, DEST_PIN);
      timer_freq_sel_in <= 3'h0;
      timer_cascade_in <= 2'h1;
      timer_base_count_in[0] <= 31'h2;
      timer_base_count_in[1] <= 31'h3;
      timer_base_count_in[2] <= 31'h4;
      timer_inhibit_in <= 4'h8;
      timer_load_in <= 4'h7;
      @(posedge clk_in);
      timer_load_in <= '0;
      cyc(5);
      check("irq_pin_out", 0, irq_pin_out);
      check("timer count", 1, timer_current_count_out[1]);
      check("timer count", 3, timer_current_count_out[2]);
      cyc(2);
      check("irq_pin_out", 1, irq_pin_out);
      check("timer count", 3, timer_current_count_out[1]);
      @(posedge clk_in);
      timer_inhibit_in <= '1;
      timer_cascade_in <= '0;
      $display("t_cascade done");
   endtask

   task automatic summarize();
      $display("checks %0d, mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // Watchdog well beyond the few hundred cycles the tests need
   initial
   begin
      repeat (3000) @(posedge clk_in);
      errors++;
      summarize();
   end

   initial
   begin
      cfg(12, 4'h2, 8'h12, DEST_PIN);
      cfg(34, 4'h6, 8'h34, DEST_PIN);
      cfg(38, 4'h5, 8'h26, DEST_NORMAL);
      cfg(39, 4'h8, 8'h39, DEST_NORMAL);
      cfg(40, 4'h3, 8'h40, DEST_NORMAL);
      cfg(41, 4'h9, 8'h41, DEST_CRIT);
      repeat (16) @(posedge clk_in);
      rst_n_in <= 1'b1;
      t_pass();
      t_mixed();
      t_nest();
      t_crit();
      t_ext();
      t_timer();
      t_cascade();
      summarize();
   end
endmodule
